//--- hdl/tcm_pkg.sv
// Constants shared by the tape command, modifier and status block
package tcm_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PARAM = 8'h00;
    localparam logic [7:0] OFS_MODIFIER = 8'h04;
    localparam logic [7:0] OFS_BUFPTR = 8'h08;
    localparam logic [7:0] OFS_COMMAND = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_SBUF0 = 8'h14;
    localparam logic [7:0] OFS_SBUF1 = 8'h18;
    localparam logic [7:0] OFS_SBUF2 = 8'h1C;
    localparam logic [7:0] OFS_LBUF0 = 8'h20;
    // ------------------------------------------------------------
    // Command register bits
    // ------------------------------------------------------------
    localparam int CMD_START = 0;
    localparam int CMD_SEM_CLR = 1;
    localparam int CMD_MEDIA_CLR = 2;
    // ------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------
    localparam logic [7:0] FN_LOAD = 8'h18;
    localparam logic [7:0] FN_RESET = 8'h1C;
    localparam logic [7:0] FN_RETENSION = 8'h1D;
    localparam logic [7:0] FN_RD_STATUS = 8'h1E;
    localparam logic [7:0] FN_TERMINATE = 8'h1F;
    localparam logic [7:0] FN_XFER_STATUS = 8'h0C;
    // ------------------------------------------------------------
    // Modifier word bit positions
    // ------------------------------------------------------------
    localparam int MOD_NO_IRQ = 0;
    localparam int MOD_NO_RETRY = 1;
    localparam int MOD_DELETED = 2;
    localparam int MOD_LINEAR = 3;
    localparam int MOD_LONG_STAT = 4;
    localparam int MOD_CHECKSUM = 8;
    localparam int MOD_RESTORE = 9;
    // ------------------------------------------------------------
    // Result byte, status buffer and reset values
    // ------------------------------------------------------------
    localparam int RES_HARD = 6;
    localparam int RES_ERR = 7;
    localparam int ST_BAD_FUNC = 0;
    localparam int UNITS = 4;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [3:0] DIAG_FULL = 4'h0;
    localparam logic [3:0] DIAG_CHECKSUM = 4'h1;
    localparam logic [3:0] DIAG_RESTORE = 4'h2;
    localparam logic [3:0] RETRY_NONE = 4'h1;
    localparam logic [3:0] RETRY_DEFAULT = 4'h8;
    typedef enum logic [2:0] {
        S_IDLE, S_ISSUE, S_SUMM, S_POST
    } tcm_state_t;
endpackage

//--- hdl/tcm_ctrl.sv
// Tape command interpreter with modifier decode and status posting
`timescale 1ns/10ps
module tcm_ctrl (
    input wire logic clk_in, // 25 MHz clock
    input wire logic rst_in, // Async reset, active high
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [7:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error, unmapped
    input wire logic drv_ack_in, // Drive accepted command / started
    input wire logic drv_writing_in, // Transfer in progress is a write
    input wire logic [3:0] drv_done_in, // Off-line part done per unit
    input wire logic [3:0] drv_cart_in, // Cartridge present per unit
    input wire logic [95:0] drv_status_in, // Twelve status bytes
    output logic cmd_valid_out, // Command request to drive
    output logic [7:0] cmd_func_out, // Function code to drive
    output logic [1:0] cmd_unit_out, // Unit to drive
    output logic cmd_filemark_out, // Record one file mark
    output logic cmd_rewind_out, // Rewind to beginning marker
    output logic irq_out, // Completion interrupt to host
    output logic [23:0] buf_addr_out, // Data buffer address
    output logic deleted_out, // Floppy deleted-data transfers
    output logic [3:0] retries_out, // Hard disk attempt limit
    output logic [3:0] diag_mode_out // Diagnostic variant
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] summarize(input logic [95:0] b,
        input logic [1:0] u, input logic [3:0] code);
        logic err;
        logic hard;
        err = |b[23:0];
        hard = b[0] | b[1] | b[2] | b[6];
        return {err, hard & err, u, code};
    endfunction

    function automatic logic is_long(input logic [7:0] f);
        return f == tcm_pkg::FN_LOAD || f == tcm_pkg::FN_RESET ||
            f == tcm_pkg::FN_RETENSION;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tcm_pkg::tcm_state_t state;
    logic [15:0] dev_code;
    logic [7:0] unit_reg;
    logic [7:0] func_reg;
    logic [15:0] modifier;
    logic [31:0] bufptr;
    logic [7:0] cur_func;
    logic [1:0] cur_unit;
    logic [15:0] cur_mod;
    logic [3:0] cur_code;
    logic [95:0] sbuf;
    logic [95:0] lbuf;
    logic [7:0] result;
    logic sem;
    logic post_lt;
    logic [3:0] pending;
    logic [3:0] done_req;
    logic [3:0] watch;
    logic [3:0] cart_q;
    logic [3:0] media_chg;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire setup = psel_in & ~penable_in;
    wire wr = psel_in & penable_in & pwrite_in & pready_out;
    wire wr_cmd = wr && paddr_in == tcm_pkg::OFS_COMMAND;
    wire start = wr_cmd & pwdata_in[tcm_pkg::CMD_START];
    wire sem_clr = wr_cmd & pwdata_in[tcm_pkg::CMD_SEM_CLR];
    wire media_clr = wr_cmd & pwdata_in[tcm_pkg::CMD_MEDIA_CLR];
    wire idle = state == tcm_pkg::S_IDLE;
    wire [31:0] status_word = {14'h0000, media_chg, pending,
        ~idle, sem, result};
    logic [31:0] rd_data;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        if (paddr_in == tcm_pkg::OFS_PARAM) begin
            rd_data = {func_reg, unit_reg, dev_code};
        end else if (paddr_in == tcm_pkg::OFS_MODIFIER) begin
            rd_data = {16'h0000, modifier};
        end else if (paddr_in == tcm_pkg::OFS_BUFPTR) begin
            rd_data = bufptr;
        end else if (paddr_in == tcm_pkg::OFS_COMMAND) begin
            rd_data = 32'h0000_0000;
        end else if (paddr_in == tcm_pkg::OFS_STATUS) begin
            rd_data = status_word;
        end else if (paddr_in == tcm_pkg::OFS_SBUF0) begin
            rd_data = sbuf[31:0];
        end else if (paddr_in == tcm_pkg::OFS_SBUF1) begin
            rd_data = sbuf[63:32];
        end else if (paddr_in == tcm_pkg::OFS_SBUF2) begin
            rd_data = sbuf[95:64];
        end else begin
            rd_data = 32'h0000_0000;
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= setup;
            pslverr_out <= setup & ~rd_hit;
            prdata_out <= (setup & ~pwrite_in) ? rd_data : 32'h0000_0000;
        end
    end

    // parameter block fields held for the host
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dev_code <= 16'h0000;
            unit_reg <= 8'h00;
            func_reg <= 8'h00;
            modifier <= 16'h0000;
            bufptr <= 32'h0000_0000;
        end else if (wr && paddr_in == tcm_pkg::OFS_PARAM) begin
            {func_reg, unit_reg, dev_code} <= pwdata_in;
        end else if (wr && paddr_in == tcm_pkg::OFS_MODIFIER) begin
            modifier <= pwdata_in[15:0];
        end else if (wr && paddr_in == tcm_pkg::OFS_BUFPTR) begin
            bufptr <= pwdata_in;
        end
    end

    // ------------------------------------------------------------
    // Modifier decode
    // ------------------------------------------------------------
    // linear or segment:offset pointer
    wire [19:0] seg_addr = {bufptr[31:16], 4'h0} + {4'h0, bufptr[15:0]};
    wire [23:0] next_buf_addr = modifier[tcm_pkg::MOD_LINEAR] ?
        bufptr[23:0] : {4'h0, seg_addr};
    wire [3:0] next_diag = modifier[tcm_pkg::MOD_CHECKSUM] ?
        tcm_pkg::DIAG_CHECKSUM : modifier[tcm_pkg::MOD_RESTORE] ?
        tcm_pkg::DIAG_RESTORE : tcm_pkg::DIAG_FULL;

    // modifier bits take effect at start
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            buf_addr_out <= 24'h00_0000;
            deleted_out <= 1'b0;
            retries_out <= tcm_pkg::RETRY_DEFAULT;
            diag_mode_out <= tcm_pkg::DIAG_FULL;
        end else if (start && idle && !sem) begin
            buf_addr_out <= next_buf_addr;
            deleted_out <= modifier[tcm_pkg::MOD_DELETED];
            retries_out <= modifier[tcm_pkg::MOD_NO_RETRY] ?
                tcm_pkg::RETRY_NONE : tcm_pkg::RETRY_DEFAULT;
            diag_mode_out <= next_diag;
        end
    end

    // ------------------------------------------------------------
    // Media change watch
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cart_q <= 4'h0;
            media_chg <= 4'h0;
        end else begin
            cart_q <= drv_cart_in;
            // watched units flag a cartridge change
            media_chg <= (media_clr ? 4'h0 : media_chg) |
                (watch & (cart_q ^ drv_cart_in));
        end
    end

    // ------------------------------------------------------------
    // Off-line completion tracking
    // ------------------------------------------------------------
    wire [3:0] done_evt = drv_done_in & pending;
    wire any_req = |done_req;
    wire [1:0] req_unit = done_req[0] ? 2'd0 : done_req[1] ? 2'd1 :
        done_req[2] ? 2'd2 : 2'd3;
    // late completion only with semaphore free
    wire serve_req = idle && !sem && any_req && !start;
    wire begin_cmd = idle && !sem && start;

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= tcm_pkg::S_IDLE;
            cur_func <= 8'h00;
            cur_unit <= 2'd0;
            cur_mod <= 16'h0000;
            cur_code <= 4'h0;
            cmd_valid_out <= 1'b0;
            cmd_func_out <= 8'h00;
            cmd_unit_out <= 2'd0;
            cmd_filemark_out <= 1'b0;
            cmd_rewind_out <= 1'b0;
            sbuf <= 96'h0;
            lbuf <= 96'h0;
            result <= tcm_pkg::RESULT_RST;
            sem <= 1'b0;
            irq_out <= 1'b0;
            post_lt <= 1'b0;
            pending <= 4'h0;
            done_req <= 4'h0;
            watch <= 4'h0;
        end else begin
            done_req <= done_req | done_evt;
            if (|done_evt) begin
                lbuf <= drv_status_in;
            end
            if (sem_clr) begin
                sem <= 1'b0;
                irq_out <= 1'b0;
            end
            case (state)
                tcm_pkg::S_IDLE: begin
                    if (begin_cmd) begin
                        cur_func <= func_reg;
                        cur_unit <= unit_reg[1:0];
                        cur_mod <= modifier;
                        cur_code <= dev_code[3:0];
                        post_lt <= 1'b0;
                        if (func_reg == tcm_pkg::FN_RD_STATUS) begin
                            sbuf <= drv_status_in;
                            state <= tcm_pkg::S_SUMM;
                        end else if (func_reg == tcm_pkg::FN_XFER_STATUS)
                        begin
                            if (modifier[tcm_pkg::MOD_LONG_STAT]) begin
                                sbuf <= lbuf;
                            end
                            state <= tcm_pkg::S_SUMM;
                        end else if (is_long(func_reg) ||
                            func_reg == tcm_pkg::FN_TERMINATE) begin
                            cmd_valid_out <= 1'b1;
                            cmd_func_out <= func_reg;
                            cmd_unit_out <= unit_reg[1:0];
                            // write end gets one file mark
                            cmd_filemark_out <= func_reg ==
                                tcm_pkg::FN_TERMINATE && drv_writing_in;
                            cmd_rewind_out <= func_reg == tcm_pkg::FN_LOAD
                                || (func_reg == tcm_pkg::FN_TERMINATE &&
                                !drv_writing_in);
                            state <= tcm_pkg::S_ISSUE;
                        end else begin
                            sbuf <= 96'h1 << tcm_pkg::ST_BAD_FUNC;
                            state <= tcm_pkg::S_SUMM;
                        end
                    end else if (serve_req) begin
                        cur_unit <= req_unit;
                        done_req[req_unit] <= 1'b0;
                        pending[req_unit] <= 1'b0;
                        post_lt <= 1'b1;
                        state <= tcm_pkg::S_SUMM;
                    end
                end
                tcm_pkg::S_ISSUE: begin
                    if (drv_ack_in) begin
                        cmd_valid_out <= 1'b0;
                        sbuf <= drv_status_in;
                        if (is_long(cur_func)) begin
                            pending[cur_unit] <= 1'b1;
                        end
                        if (cur_func == tcm_pkg::FN_LOAD) begin
                            watch[cur_unit] <= 1'b1;
                        end
                        state <= tcm_pkg::S_SUMM;
                    end
                end
                tcm_pkg::S_SUMM: begin
                    result <= summarize(post_lt ? lbuf : sbuf, cur_unit,
                        cur_code);
                    state <= tcm_pkg::S_POST;
                end
                tcm_pkg::S_POST: begin
                    sem <= 1'b1;
                    // only the first interrupt is suppressible
                    irq_out <= post_lt | ~cur_mod[tcm_pkg::MOD_NO_IRQ];
                    state <= tcm_pkg::S_IDLE;
                end
                default: begin
                    state <= tcm_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // load issued to drive
    chk_load_issue: assert property (
        @(posedge clk_in) disable iff (rst_in)
        begin_cmd && func_reg == tcm_pkg::FN_LOAD |=> cmd_valid_out &&
        cmd_func_out == tcm_pkg::FN_LOAD && cmd_rewind_out)
        else $error("load not issued");
    chk_offline_irq: assert property (
        @(posedge clk_in) disable iff (rst_in)
        serve_req |=> ##2 irq_out && sem)
        else $error("completion interrupt missing");
    chk_sem_wait: assert property (
        @(posedge clk_in) disable iff (rst_in)
        sem && idle && !sem_clr |=> idle)
        else $error("posted while semaphore held");
    chk_rdstat_still: assert property (@(posedge clk_in)
        disable iff (rst_in) begin_cmd && func_reg == tcm_pkg::FN_RD_STATUS
        |=> !cmd_valid_out ##1 !cmd_valid_out)
        else $error("read status moved tape");
    chk_term_mark: assert property (
        @(posedge clk_in) disable iff (rst_in)
        begin_cmd && func_reg == tcm_pkg::FN_TERMINATE && drv_writing_in
        |=> cmd_filemark_out && !cmd_rewind_out)
        else $error("file mark missing");
    chk_irq_suppress: assert property (@(posedge clk_in)
        disable iff (rst_in) state == tcm_pkg::S_POST && !post_lt &&
        cur_mod[tcm_pkg::MOD_NO_IRQ] |=> !irq_out)
        else $error("suppressed interrupt raised");
    chk_linear_ptr: assert property (
        @(posedge clk_in) disable iff (rst_in)
        begin_cmd && modifier[tcm_pkg::MOD_LINEAR] |=>
        buf_addr_out == $past(bufptr[23:0]))
        else $error("linear pointer wrong");
    chk_result_first: assert property (@(posedge clk_in)
        disable iff (rst_in) $rose(irq_out) |-> $past(state, 2) ==
        tcm_pkg::S_SUMM && result[5:4] == cur_unit)
        else $error("interrupt before summary");
    chk_err_bit: assert property (
        @(posedge clk_in) disable iff (rst_in)
        state == tcm_pkg::S_SUMM && !post_lt && |sbuf[23:0] |=>
        result[tcm_pkg::RES_ERR])
        else $error("error bit not set");
    chk_no_retry: assert property (
        @(posedge clk_in) disable iff (rst_in)
        begin_cmd && modifier[tcm_pkg::MOD_NO_RETRY] |=>
        retries_out == tcm_pkg::RETRY_NONE)
        else $error("retries not inhibited");
endmodule // tcm_ctrl

//--- sim/tcm_drive_model.sv
// Behavioural tape drive answering the command interface
`timescale 1ns/10ps
module tcm_drive_model (
    input wire logic clk_in, // 25 MHz clock
    input wire logic rst_in, // Async reset, active high
    input wire logic cmd_valid_in, // Command request from block
    input wire logic [3:0] ack_dly_in, // Cycles before motion starts
    input wire logic [3:0] fin_in, // Finish off-line part per unit
    output logic drv_ack_out, // Motion started
    output logic [3:0] drv_done_out // Off-line part done, one cycle
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_cnt <= 4'h0;
            drv_ack_out <= 1'b0;
        end else if (!cmd_valid_in) begin
            wait_cnt <= 4'h0;
            drv_ack_out <= 1'b0;
        end else if (wait_cnt == ack_dly_in) begin
            drv_ack_out <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            drv_done_out <= 4'h0;
        end else begin
            drv_done_out <= fin_in;
        end
    end
endmodule // tcm_drive_model

//--- sim/tcm_ctrl_test.sv
// Self-checking bench for the tape command interpreter
`timescale 1ns/10ps
module tcm_ctrl_test;
    typedef struct packed {
        logic [7:0] fn;
        logic [1:0] unit;
        logic wr;
        logic lt;
        logic [23:0] st;
        logic [7:0] res;
    } tcm_row_t;
    logic clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, drv_ack, drv_writing = 1'b0;
    logic [7:0] paddr = 8'h00, cmd_func;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] drv_done, fin = 4'h0, dly = 4'h0, retries, diag;
    logic [3:0] cart = 4'hF;
    logic [95:0] drv_status = 96'h0;
    logic cmd_valid, filemark, rewind, irq, deleted, err;
    logic [1:0] cmd_unit;
    logic [23:0] buf_addr;
    int miscompares = 0, n_tests = 0, cyc = 0;
    tcm_row_t rows [7] = '{
        '{8'h1C, 2'd2, 1'b0, 1'b1, 24'h000100, 8'hA5},
        '{8'h18, 2'd1, 1'b0, 1'b1, 24'h000000, 8'h15},
        '{8'h1D, 2'd3, 1'b0, 1'b1, 24'h000004, 8'hF5},
        '{8'h1E, 2'd0, 1'b0, 1'b0, 24'h010000, 8'h85},
        '{8'h1F, 2'd1, 1'b1, 1'b0, 24'h000000, 8'h15},
        '{8'h1F, 2'd2, 1'b0, 1'b0, 24'h000000, 8'h25},
        '{8'h33, 2'd0, 1'b0, 1'b0, 24'h000000, 8'hC5}};
    tcm_ctrl tcm_ctrl_inst (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .drv_ack_in(drv_ack), .drv_writing_in(drv_writing),
        .drv_done_in(drv_done), .drv_cart_in(cart),
        .drv_status_in(drv_status), .cmd_valid_out(cmd_valid),
        .cmd_func_out(cmd_func), .cmd_unit_out(cmd_unit),
        .cmd_filemark_out(filemark), .cmd_rewind_out(rewind),
        .irq_out(irq), .buf_addr_out(buf_addr), .deleted_out(deleted),
        .retries_out(retries), .diag_mode_out(diag));
    tcm_drive_model tcm_drive_model_inst (.clk_in(clk_in),
        .rst_in(rst_in), .cmd_valid_in(cmd_valid), .ack_dly_in(dly),
        .fin_in(fin), .drv_ack_out(drv_ack), .drv_done_out(drv_done));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic start(input logic [7:0] fn, input logic [1:0] u,
                         input logic [15:0] m);
        apb(1'b1, tcm_pkg::OFS_PARAM, {fn, 6'h00, u, 16'h0005});
        apb(1'b1, tcm_pkg::OFS_MODIFIER, {16'h0000, m});
        apb(1'b1, tcm_pkg::OFS_COMMAND, 32'h00000001);
    endtask
    task automatic wait_sem(input logic [7:0] res, input logic q);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, tcm_pkg::OFS_STATUS, 32'h0);
            if (rd[8] === 1'b1) break;
        end
        chk(rd[7:0], res);
        chk(irq, q);
        apb(1'b1, tcm_pkg::OFS_COMMAND, 32'h00000002);
        @(posedge clk_in);
        chk(irq, 1'b0);
    endtask
    task automatic finish_unit(input logic [1:0] u);
        @(posedge clk_in);
        fin <= 4'h1 << u;
        @(posedge clk_in);
        fin <= 4'h0;
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk({irq, retries}, 5'h08);
        apb(1'b0, tcm_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, tcm_pkg::OFS_LBUF0, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("reset and map test done");
        foreach (rows[i]) begin
            drv_status <= {72'h0, rows[i].st};
            drv_writing <= rows[i].wr;
            start(rows[i].fn, rows[i].unit, 16'h0000);
            if (rows[i].fn inside {8'h18, 8'h1C, 8'h1D, 8'h1F}) begin
                for (int j = 0; j < 20 && cmd_valid !== 1'b1; j++)
                    @(negedge clk_in);
                chk(cmd_valid, 1'b1);
                chk(cmd_func, rows[i].fn);
                chk(cmd_unit, rows[i].unit);
                if (rows[i].fn == 8'h1F) begin
                    chk(filemark, rows[i].wr);
                    chk(rewind, !rows[i].wr);
                end
            end
            wait_sem(rows[i].res, 1'b1);
            if (rows[i].lt) begin
                finish_unit(rows[i].unit);
                wait_sem(rows[i].res, 1'b1);
            end
        end
        $display("function table test done");
        drv_status <= 96'h0;
        start(8'h1D, 2'd0, 16'h0001);
        wait_sem(8'h05, 1'b0);
        finish_unit(2'd0);
        wait_sem(8'h05, 1'b1);
        dly <= 4'h8;
        start(8'h18, 2'd3, 16'h0000);
        wait_sem(8'h35, 1'b1);
        cart <= 4'h7;
        apb(1'b0, tcm_pkg::OFS_STATUS, 32'h0);
        chk(rd[17:14], 4'h8);
        apb(1'b1, tcm_pkg::OFS_COMMAND, 32'h00000004);
        apb(1'b0, tcm_pkg::OFS_STATUS, 32'h0);
        chk(rd[17:14], 4'h0);
        drv_status <= {64'h0, 32'h0F000000};
        start(8'h1E, 2'd0, 16'h0000);
        for (int i = 0; i < 20 && rd[8] !== 1'b1; i++)
            apb(1'b0, tcm_pkg::OFS_STATUS, 32'h0);
        drv_status <= {64'h0, 32'h00000200};
        finish_unit(2'd3);
        repeat (6) @(posedge clk_in);
        apb(1'b0, tcm_pkg::OFS_SBUF0, 32'h0);
        chk(rd, 32'h0F000000);
        wait_sem(8'h05, 1'b1);
        wait_sem(8'hB5, 1'b1);
        start(tcm_pkg::FN_XFER_STATUS, 2'd0, 16'h0010);
        wait_sem(8'h85, 1'b1);
        apb(1'b0, tcm_pkg::OFS_SBUF0, 32'h0);
        chk(rd, 32'h00000200);
        $display("off-line and status test done");
        drv_status <= 96'h0;
        apb(1'b1, tcm_pkg::OFS_BUFPTR, 32'h00563412);
        start(8'h1E, 2'd0, 16'h010E);
        wait_sem(8'h05, 1'b1);
        chk(buf_addr, 24'h563412);
        chk(retries, tcm_pkg::RETRY_NONE);
        chk(deleted, 1'b1);
        chk(diag, tcm_pkg::DIAG_CHECKSUM);
        apb(1'b1, tcm_pkg::OFS_BUFPTR, 32'h10000010);
        start(8'h1E, 2'd0, 16'h0200);
        wait_sem(8'h05, 1'b1);
        chk(buf_addr, 24'h010010);
        chk({deleted, retries}, {1'b0, tcm_pkg::RETRY_DEFAULT});
        chk(diag, tcm_pkg::DIAG_RESTORE);
        $display("modifier test done");
        finish_test();
    end
endmodule // tcm_ctrl_test
